// ### logic/pcmd_pkg.sv
package pcmd_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int LD_MAX_KPPS = 500;
  localparam int OC_MAX_KPPS = 200;
  localparam int LR_MAX_KPPS = 4000;
  // Fastest legal pulse period in clock cycles, rounded down.
  localparam int LR_MIN_CYC = CLK_HZ / (LR_MAX_KPPS * 1000);
  localparam int LD_MIN_CYC = CLK_HZ / (LD_MAX_KPPS * 1000);
  // Synchroniser plus edge detect needs each level held this long.
  localparam int MIN_PULSE_CYC = 4;
  localparam int ABS_BIT_NS = 1000;
  localparam int ABS_BIT_CYC = ABS_BIT_NS * (CLK_HZ / 1_000_000) / 1000;

  typedef enum logic [1:0] {
    FMT_QUAD0 = 2'h0,
    FMT_SEP   = 2'h1,
    FMT_QUAD2 = 2'h2,
    FMT_DIR   = 2'h3
  } pulse_fmt_t;

  typedef enum logic [1:0] {
    ABS_IDLE = 2'h0,
    ABS_SER  = 2'h1,
    ABS_PUL  = 2'h3,
    ABS_DONE = 2'h2
  } abs_state_t;

  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STAT   = 4'h1;
  localparam logic [3:0] ADDR_POS_LO = 4'h2;
  localparam logic [3:0] ADDR_POS_HI = 4'h3;

  localparam int CTL_PATH = 0;
  localparam int CTL_INV = 1;
  localparam int CTL_FMT = 2;
  localparam int CTL_ABS = 4;
  localparam int CTL_RUN_ASG = 5;
  localparam int CTL_POS_CLR = 6;
  localparam logic [5:0] CTRL_RST = 6'h00;

  localparam int STS_SERVO = 0;
  localparam int STS_SENSOR = 1;
  localparam int STS_BUSY = 2;
  localparam int STS_DONE = 3;
  localparam int STS_ENC_RDY = 4;
endpackage : pcmd_pkg

// ### logic/pulse_decode.sv
`timescale 1ns/10ps
module pulse_decode (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                a_in,
  input  wire logic                b_in,
  input  wire pcmd_pkg::pulse_fmt_t fmt,
  output logic                     fwd_ff,
  output logic                     rev_ff
);
  import pcmd_pkg::*;

  logic [1:0] a_sync_ff;
  logic [1:0] b_sync_ff;
  logic       a_q_ff;
  logic       b_q_ff;
  logic       a_rise;
  logic       b_rise;
  logic [1:0] idx_cur;
  logic [1:0] idx_prev;
  logic [1:0] idx_diff;
  logic       nxt_fwd;
  logic       nxt_rev;

  // Stage 0 feeds only stage 1; all decoding looks at stage 1.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      a_sync_ff <= 2'h0;
      b_sync_ff <= 2'h0;
      a_q_ff    <= 1'b0;
      b_q_ff    <= 1'b0;
    end else begin
      a_sync_ff <= {a_sync_ff[0], a_in};
      b_sync_ff <= {b_sync_ff[0], b_in};
      a_q_ff    <= a_sync_ff[1];
      b_q_ff    <= b_sync_ff[1];
    end
  end

  assign a_rise = a_sync_ff[1] & ~a_q_ff;
  assign b_rise = b_sync_ff[1] & ~b_q_ff;
  assign idx_cur = {a_sync_ff[1], a_sync_ff[1] ^ b_sync_ff[1]};
  assign idx_prev = {a_q_ff, a_q_ff ^ b_q_ff};
  assign idx_diff = idx_prev - idx_cur;

  always_comb begin
    nxt_fwd = 1'b0;
    nxt_rev = 1'b0;
    case (fmt)
      FMT_QUAD0, FMT_QUAD2: begin
        // A double step is a lost edge and counts as nothing.
        nxt_fwd = (idx_diff == 2'h1);
        nxt_rev = (idx_diff == 2'h3);
      end
      FMT_SEP: begin
        nxt_fwd = b_rise & ~a_rise;
        nxt_rev = a_rise & ~b_rise;
      end
      FMT_DIR: begin
        nxt_fwd = a_rise & b_sync_ff[1];
        nxt_rev = a_rise & ~b_sync_ff[1];
      end
      default: begin
        nxt_fwd = 1'b0;
        nxt_rev = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fwd_ff <= 1'b0;
      rev_ff <= 1'b0;
    end else begin
      fwd_ff <= nxt_fwd;
      rev_ff <= nxt_rev;
    end
  end

  quad_fwd_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fmt == FMT_QUAD0 && !a_q_ff && !b_q_ff && a_sync_ff[1] && !b_sync_ff[1])
    |=> fwd_ff && !rev_ff) else $error("quadrature forward step missed");
  sep_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fmt == FMT_SEP && a_rise && !b_rise) |=> rev_ff && !fwd_ff)
    else $error("separate reverse pulse missed");
  sync_lat_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fmt == FMT_DIR && !a_in) ##1 (fmt == FMT_DIR && a_in && b_in) ##1 (fmt == FMT_DIR)
    ##1 (fmt == FMT_DIR) |=> fwd_ff)
    else $error("feed pulse not counted three cycles after it arrived");
endmodule : pulse_decode

// ### logic/abs_sender.sv
`timescale 1ns/10ps
module abs_sender #(
  parameter int MT_W    = 16,
  parameter int ST_W    = 16,
  parameter int BIT_CYC = pcmd_pkg::ABS_BIT_CYC
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            start,
  input  wire logic            active,
  input  wire logic [MT_W-1:0] multi_turn,
  input  wire logic [ST_W-1:0] single_turn,
  output logic                 ser_ff,
  output logic                 inc_a_ff,
  output logic                 inc_b_ff,
  output pcmd_pkg::abs_state_t state_ff
);
  import pcmd_pkg::*;

  localparam int DIV_W = $clog2(BIT_CYC + 1);
  localparam int CNT_W = $clog2(MT_W + 1);

  if (BIT_CYC < 2) begin : g_bad
    $error("abs_sender: BIT_CYC below 2");
  end

  logic [DIV_W-1:0] div_ff;
  logic             tick;
  logic [MT_W-1:0]  mt_sh_ff;
  logic [CNT_W-1:0] bit_ff;
  logic [ST_W-1:0]  rem_ff;
  logic [1:0]       q_ff;
  logic [1:0]       nxt_q;

  assign tick = (div_ff == DIV_W'(BIT_CYC - 1));
  assign nxt_q = q_ff + 2'h1;

  always_ff @(posedge clk) begin
    if (!rst_n || state_ff == ABS_IDLE || tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + DIV_W'(1);
    end
  end

  // Dropping sensor-on aborts at once so a restart always sends all data.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ABS_IDLE;
      mt_sh_ff <= '0;
      bit_ff   <= '0;
      rem_ff   <= '0;
    end else if (!active) begin
      state_ff <= ABS_IDLE;
    end else begin
      case (state_ff)
        ABS_IDLE: begin
          if (start) begin
            state_ff <= ABS_SER;
            mt_sh_ff <= multi_turn;
            rem_ff   <= single_turn;
            bit_ff   <= '0;
          end
        end
        ABS_SER: begin
          if (tick) begin
            mt_sh_ff <= mt_sh_ff >> 1;
            bit_ff   <= bit_ff + CNT_W'(1);
            if (bit_ff == CNT_W'(MT_W - 1)) begin
              state_ff <= ABS_PUL;
            end
          end
        end
        ABS_PUL: begin
          if (rem_ff == '0) begin
            state_ff <= ABS_DONE;
          end else if (tick) begin
            rem_ff <= rem_ff - ST_W'(1);
          end
        end
        ABS_DONE: state_ff <= ABS_DONE;
        default: state_ff <= ABS_IDLE;
      endcase
    end
  end

  // Incremental output walks 00,10,11,01 so phase A leads: a forward count.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ser_ff   <= 1'b0;
      q_ff     <= 2'h0;
      inc_a_ff <= 1'b0;
      inc_b_ff <= 1'b0;
    end else begin
      ser_ff <= (state_ff == ABS_SER) & mt_sh_ff[0];
      if (state_ff == ABS_PUL && tick && rem_ff != '0) begin
        q_ff     <= nxt_q;
        inc_a_ff <= nxt_q[0] ^ nxt_q[1];
        inc_b_ff <= nxt_q[1];
      end
    end
  end

  ser_order_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == ABS_SER && active && tick && bit_ff == CNT_W'(MT_W - 1))
    |=> state_ff == ABS_PUL) else $error("pulses did not follow serial data");
endmodule : abs_sender

// ### logic/pulse_cmd_in.sv
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module pulse_cmd_in #(
  parameter int POS_W = 32,
  parameter int MT_W  = 16,
  parameter int ST_W  = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [3:0]       addr,
  input  wire logic [15:0]      wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic      [15:0]      rdata_ff,
  input  wire logic             reverse_pulse_in,
  input  wire logic             forward_pulse_in,
  input  wire logic             lr_reverse_pulse_in,
  input  wire logic             lr_forward_pulse_in,
  input  wire logic             sensor_on_in,
  input  wire logic             run_cmd_in,
  input  wire logic             enc_ready_in,
  input  wire logic [MT_W-1:0]  enc_multi_turn,
  input  wire logic [ST_W-1:0]  enc_single_turn,
  output logic                  servo_enable_ff,
  output logic signed [1:0]     cmd_step_ff,
  output logic      [POS_W-1:0] pos_ff,
  output logic                  abs_serial_out,
  output logic                  abs_inc_a_out,
  output logic                  abs_inc_b_out
);
  import pcmd_pkg::*;

  // Both paths must be sampled at least MIN_PULSE_CYC per pulse period.
  if (LR_MIN_CYC < MIN_PULSE_CYC || LD_MIN_CYC < MIN_PULSE_CYC) begin : g_rate
    $error("pulse_cmd_in: clock too slow for the top pulse rate");
  end
  if (POS_W <= 16 || POS_W > 32) begin : g_posw
    $error("pulse_cmd_in: POS_W must be 17 to 32");
  end

  logic [5:0]       ctrl_ff;
  logic             pos_clr_ff;
  logic             sensor_q_ff;
  logic             pc_fwd;
  logic             pc_rev;
  logic             lr_fwd;
  logic             lr_rev;
  logic             sel_fwd;
  logic             sel_rev;
  logic             fwd;
  logic             rev;
  logic             abs_en;
  logic             sensor_act;
  logic             abs_start;
  logic             sensor_ok;
  logic             nxt_servo;
  logic signed [1:0] nxt_step;
  logic [15:0]      nxt_rdata;
  logic [31:0]      pos_ext;
  abs_state_t       abs_state;
  pulse_fmt_t       fmt;

  assign fmt = pulse_fmt_t'(ctrl_ff[CTL_FMT +: 2]);
  assign abs_en = ctrl_ff[CTL_ABS];

  // Pins are taken as already high when the LED conducts, so no inversion.
  pulse_decode u_pc_dec (
    .clk    (clk),
    .rst_n  (rst_n),
    .a_in   (reverse_pulse_in),
    .b_in   (forward_pulse_in),
    .fmt    (fmt),
    .fwd_ff (pc_fwd),
    .rev_ff (pc_rev)
  );

  pulse_decode u_lr_dec (
    .clk    (clk),
    .rst_n  (rst_n),
    .a_in   (lr_reverse_pulse_in),
    .b_in   (lr_forward_pulse_in),
    .fmt    (fmt),
    .fwd_ff (lr_fwd),
    .rev_ff (lr_rev)
  );

  assign sel_fwd = ctrl_ff[CTL_PATH] ? lr_fwd : pc_fwd;
  assign sel_rev = ctrl_ff[CTL_PATH] ? lr_rev : pc_rev;
  assign fwd = ctrl_ff[CTL_INV] ? sel_rev : sel_fwd;
  assign rev = ctrl_ff[CTL_INV] ? sel_fwd : sel_rev;

  always_comb begin
    nxt_step = 2'sh0;
    if (fwd && !rev) begin
      nxt_step = 2'sh1;
    end else if (rev && !fwd) begin
      nxt_step = -2'sh1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_step_ff <= 2'sh0;
    end else begin
      cmd_step_ff <= nxt_step;
    end
  end

  // A clear written in the same cycle as a step drops that step.
  always_ff @(posedge clk) begin
    if (!rst_n || pos_clr_ff) begin
      pos_ff <= '0;
    end else begin
      pos_ff <= pos_ff + POS_W'(signed'(cmd_step_ff));
    end
  end

  assign sensor_act = abs_en & sensor_on_in;
  assign abs_start = sensor_act & ~sensor_q_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sensor_q_ff <= 1'b0;
    end else begin
      sensor_q_ff <= sensor_act;
    end
  end

  abs_sender #(
    .MT_W    (MT_W),
    .ST_W    (ST_W),
    .BIT_CYC (ABS_BIT_CYC)
  ) u_abs (
    .clk         (clk),
    .rst_n       (rst_n),
    .start       (abs_start),
    .active      (sensor_act),
    .multi_turn  (enc_multi_turn),
    .single_turn (enc_single_turn),
    .ser_ff      (abs_serial_out),
    .inc_a_ff    (abs_inc_a_out),
    .inc_b_ff    (abs_inc_b_out),
    .state_ff    (abs_state)
  );

  // With the absolute interface off, sensor-on only shows in the status word.
  assign sensor_ok = !abs_en || (sensor_on_in && abs_state == ABS_DONE);
  assign nxt_servo = ctrl_ff[CTL_RUN_ASG] & run_cmd_in
                   & enc_ready_in & sensor_ok;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      servo_enable_ff <= 1'b0;
    end else begin
      servo_enable_ff <= nxt_servo;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff    <= CTRL_RST;
      pos_clr_ff <= 1'b0;
    end else begin
      pos_clr_ff <= wr && addr == ADDR_CTRL && wdata[CTL_POS_CLR];
      if (wr && addr == ADDR_CTRL) begin
        ctrl_ff <= wdata[5:0];
      end
    end
  end

  assign pos_ext = 32'(pos_ff);

  always_comb begin
    nxt_rdata = 16'h0000;
    case (addr)
      ADDR_CTRL: nxt_rdata[5:0] = ctrl_ff;
      ADDR_STAT: begin
        nxt_rdata[STS_SERVO]   = servo_enable_ff;
        nxt_rdata[STS_SENSOR]  = sensor_on_in;
        nxt_rdata[STS_BUSY]    = abs_state == ABS_SER || abs_state == ABS_PUL;
        nxt_rdata[STS_DONE]    = abs_state == ABS_DONE;
        nxt_rdata[STS_ENC_RDY] = enc_ready_in;
      end
      ADDR_POS_LO: nxt_rdata = pos_ext[15:0];
      ADDR_POS_HI: nxt_rdata = pos_ext[31:16];
      default: nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else if (rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  run_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !run_cmd_in |=> !servo_enable_ff) else $error("servo on without run command");
  no_assign_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl_ff[CTL_RUN_ASG] |=> !servo_enable_ff)
    else $error("servo on with run command unassigned");
  sensor_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (abs_en && (!sensor_on_in || !enc_ready_in)) |=> !servo_enable_ff)
    else $error("servo on before sensor-on and encoder ready");
  sensor_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!abs_en && abs_state == ABS_IDLE) |=> abs_state == ABS_IDLE)
    else $error("sensor-on acted with absolute interface off");
  abs_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (abs_en && sensor_on_in && !sensor_q_ff && abs_state == ABS_IDLE)
    |=> abs_state == ABS_SER) else $error("sensor-on did not start transmission");
  path_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_ff[CTL_PATH] && !ctrl_ff[CTL_INV] && lr_fwd && !lr_rev)
    |=> cmd_step_ff == 2'sh1) else $error("line receiver step not taken");
  dir_inv_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!ctrl_ff[CTL_PATH] && ctrl_ff[CTL_INV] && pc_fwd && !pc_rev)
    |=> cmd_step_ff == -2'sh1) else $error("inverted step has wrong sign");
  pos_acc_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!pos_clr_ff && cmd_step_ff == 2'sh1) |=> pos_ff == $past(pos_ff) + POS_W'(1))
    else $error("position did not advance by one");

  // Read data stand only in the cycle after the strobe, so a stale word is never seen.
  rd_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rd |=> rdata_ff == 16'h0000) else $error("read data not cleared");

  ctrl_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr == ADDR_CTRL) |=> rdata_ff == {10'h000, $past(ctrl_ff)})
    else $error("control read back wrong");

  ctrl_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == ADDR_CTRL) |=> ctrl_ff == $past(wdata[5:0]))
    else $error("control write not taken");

  clr_pos_a: assert property (@(posedge clk) disable iff (!rst_n)
    pos_clr_ff |=> pos_ff == '0) else $error("position not cleared");

  step_fwd_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fwd && !rev) |=> cmd_step_ff == 2'sh1) else $error("forward step not taken");

  step_rev_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rev && !fwd) |=> cmd_step_ff == -2'sh1) else $error("reverse step not taken");

  step_none_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!fwd && !rev) |=> cmd_step_ff == 2'sh0) else $error("step without a count");

  lr_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_ff[CTL_PATH] && !lr_fwd && !lr_rev) |=> cmd_step_ff == 2'sh0)
    else $error("unselected photocoupler path counted");

  pc_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!ctrl_ff[CTL_PATH] && !pc_fwd && !pc_rev) |=> cmd_step_ff == 2'sh0)
    else $error("unselected line receiver path counted");

  inv_fwd_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!ctrl_ff[CTL_PATH] && ctrl_ff[CTL_INV] && pc_rev && !pc_fwd)
    |=> cmd_step_ff == 2'sh1) else $error("inverted reverse step has wrong sign");

  done_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (abs_en && abs_state != ABS_DONE) |=> !servo_enable_ff)
    else $error("servo on before initial data sent");

  ready_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !enc_ready_in |=> !servo_enable_ff) else $error("servo on without encoder ready");

  run_on_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_ff[CTL_RUN_ASG] && run_cmd_in && enc_ready_in && !abs_en) |=> servo_enable_ff)
    else $error("servo off despite run command");

  sensor_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (abs_state != ABS_IDLE && !sensor_act) |=> abs_state == ABS_IDLE)
    else $error("transfer not aborted on sensor-on drop");

  stat_servo_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr == ADDR_STAT) |=> rdata_ff[STS_SERVO] == $past(servo_enable_ff))
    else $error("status servo bit wrong");

  stat_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr == ADDR_STAT && abs_state == ABS_DONE) |=> rdata_ff[STS_DONE])
    else $error("status done bit missing");

  unmapped_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr > ADDR_POS_HI) |=> rdata_ff == 16'h0000)
    else $error("unmapped read not zero");
endmodule : pulse_cmd_in

// ### tb/pulse_host.sv
`timescale 1ns/10ps
module pulse_host (
  input  wire logic       clk,
  input  wire logic [1:0] fmt,
  input  wire logic [7:0] half,
  output logic            a_out,
  output logic            b_out
);
  logic [1:0] q;

  initial begin
    a_out = 1'b0;
    b_out = 1'b0;
    q = 2'h0;
  end

  // Every level is held for half cycles; half reads path before its update, so photocoupler runs after the first get half 5, a pulse period below LD_MIN_CYC.
  task automatic hold_lv();
    repeat (half) @(posedge clk);
  endtask : hold_lv

  // One count: a whole pulse in the pulse formats, a single edge in quadrature.
  task automatic step(input logic fwd);
    @(posedge clk);
    if (fmt == 2'h1) begin
      if (fwd) b_out <= 1'b1;
      else a_out <= 1'b1;
      hold_lv();
      a_out <= 1'b0;
      b_out <= 1'b0;
      hold_lv();
    end else if (fmt == 2'h3) begin
      b_out <= fwd;
      hold_lv();
      a_out <= 1'b1;
      hold_lv();
      a_out <= 1'b0;
      b_out <= 1'b0;
      hold_lv();
    end else begin
      q = fwd ? q + 2'h1 : q - 2'h1;
      a_out <= q[0] ^ q[1];
      b_out <= q[1];
      hold_lv();
    end
  endtask : step
endmodule : pulse_host

// ### tb/pulse_cmd_in_bench.sv
`timescale 1ns/10ps
module pulse_cmd_in_bench;
  import pcmd_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0, rdata_ff, mt = 16'h0, st = 16'h0, d;
  logic sensor = 1'b0, run_cmd = 1'b0, enc_rdy = 1'b0, path = 1'b0, inv = 1'b0, fwd;
  logic servo, ser, inca, incb, ha, hb, pa, pb;
  logic signed [1:0] step, last_step_ff = 2'sb00;
  logic [31:0] pos, exp_pos = 32'h0, seed = 32'h6cf1bcc4;
  logic [1:0] hfmt = 2'h0;
  logic [7:0] half = 8'd40;
  int err_total = 0, cmp_count = 0, edges;

  always #12.5 clk = ~clk;
  pulse_host i_pulse_host (.clk(clk), .fmt(hfmt), .half(half), .a_out(ha), .b_out(hb));
  pulse_cmd_in i_pulse_cmd_in (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_ff(rdata_ff), .reverse_pulse_in(ha & ~path), .forward_pulse_in(hb & ~path),
    .lr_reverse_pulse_in(ha & path), .lr_forward_pulse_in(hb & path), .sensor_on_in(sensor),
    .run_cmd_in(run_cmd), .enc_ready_in(enc_rdy), .enc_multi_turn(mt), .enc_single_turn(st),
    .servo_enable_ff(servo), .cmd_step_ff(step), .pos_ff(pos), .abs_serial_out(ser),
    .abs_inc_a_out(inca), .abs_inc_b_out(incb));
  always @(posedge clk) if (step !== 2'sb00) last_step_ff <= step;

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr_next
  function automatic logic [31:0] pos_after(input logic [31:0] p, input logic f, input logic i);
    return (f ^ i) ? p + 32'h1 : p - 32'h1;
  endfunction : pos_after

  task automatic fail(input string m);
    err_total++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail
  task automatic chk_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) fail("bit mismatch");
  endtask : chk_bit
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) fail("word mismatch");
  endtask : chk_word
  task automatic chk_pos(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) fail("position mismatch");
  endtask : chk_pos
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata_ff;
  endtask : rd_reg
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc
  task automatic host_step(input logic f);
    i_pulse_host.step(f);
    exp_pos = pos_after(exp_pos, f, inv);
    wait_cyc(8);
    chk_pos(pos, exp_pos);
    chk_word({14'h0, last_step_ff}, (f ^ inv) ? 16'h0001 : 16'h0003);
  endtask : host_step
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(ADDR_CTRL, d);
    chk_word(d, 16'h0);
    rd_reg(4'h9, d);
    chk_word(d, 16'h0);
    // Every path, inversion and format; the pulse pair not selected stays quiet.
    for (int c = 0; c < 16; c++) begin
      wr_reg(ADDR_CTRL, c[15:0]);
      rd_reg(ADDR_CTRL, d);
      chk_word(d, c[15:0]);
      @(posedge clk);
      path <= c[0];
      inv = c[1];
      hfmt = c[3:2];
      half = path ? 8'd5 : (inv ? 8'd100 : 8'd40);
      for (int n = 0; n < 10; n++) begin
        seed = lfsr_next(seed);
        fwd = (n < 3) ? 1'b1 : seed[0];
        host_step(fwd);
      end
      while (i_pulse_host.q != 2'h0) host_step(1'b1);
      $display("test format %0d path %0d invert %0d done", c[3:2], c[0], c[1]);
    end
    rd_reg(ADDR_POS_LO, d);
    chk_word(d, exp_pos[15:0]);
    rd_reg(ADDR_POS_HI, d);
    chk_word(d, exp_pos[31:16]);
    wr_reg(ADDR_CTRL, 16'h0040);
    wait_cyc(4);
    chk_pos(pos, 32'h0);
    seed = lfsr_next(seed);
    @(posedge clk);
    mt <= seed[15:0];
    st <= {11'h0, seed[20:16]} + 16'h1;
    run_cmd <= 1'b1;
    enc_rdy <= 1'b1;
    wait_cyc(4);
    chk_bit(servo, 1'b0);
    wr_reg(ADDR_CTRL, 16'h0020);
    wait_cyc(4);
    chk_bit(servo, 1'b1);
    @(posedge clk);
    run_cmd <= 1'b0;
    wait_cyc(4);
    chk_bit(servo, 1'b0);
    @(posedge clk);
    run_cmd <= 1'b1;
    sensor <= 1'b1;
    edges = 0;
    for (int i = 0; i < 100; i++) begin
      wait_cyc(1);
      if (ser !== 1'b0 || inca !== 1'b0 || incb !== 1'b0) edges++;
    end
    chk_word(edges[15:0], 16'h0);
    chk_bit(servo, 1'b1);
    @(posedge clk);
    sensor <= 1'b0;
    wr_reg(ADDR_CTRL, 16'h0030);
    wait_cyc(4);
    chk_bit(servo, 1'b0);
    @(posedge clk);
    sensor <= 1'b1;
    wait_cyc(22);
    for (int i = 0; i < 16; i++) begin
      chk_bit(ser, mt[i]);
      chk_bit(servo, 1'b0);
      wait_cyc(40);
    end
    edges = 0;
    for (int i = 0; i < 1500 && servo !== 1'b1; i++) begin
      {pa, pb} = {inca, incb};
      wait_cyc(1);
      if ({pa, pb} !== {inca, incb}) edges++;
    end
    chk_word(edges[15:0], st);
    chk_bit(servo, 1'b1);
    rd_reg(ADDR_STAT, d);
    chk_word(d, 16'h001b);
    @(posedge clk);
    enc_rdy <= 1'b0;
    wait_cyc(4);
    chk_bit(servo, 1'b0);
    $display("test sensor and servo done");
    test_done();
  end
endmodule : pulse_cmd_in_bench
